/* File: lsc_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define LSC_OFS_UNDER_STATUS  8'h36
`define LSC_OFS_CRIT_STATUS   8'h37
`define LSC_OFS_SUPPLY_CFG    8'h50
`define LSC_OFS_SHUNT_CFG     8'h51

// ****************************************
// field positions
// ****************************************
`define LSC_BIT_SHUNT_FLAG    7
`define LSC_BIT_SUPPLY_FLAG   6
`define LSC_BIT_TEMP_FLAG     0
`define LSC_BIT_SPIKE_ROUTE   7
`define LSC_POS_SUPPLY_QUEUE  2
`define LSC_POS_SUPPLY_AVG    0
`define LSC_POS_SHUNT_QUEUE   6
`define LSC_POS_SHUNT_AVG     4
`define LSC_POS_SHUNT_PERIOD  2
`define LSC_POS_SHUNT_RANGE   0

// ****************************************
// reset values
// ****************************************
`define LSC_RST_STATUS        8'h00
`define LSC_RST_SUPPLY_CFG    8'h80
`define LSC_RST_SHUNT_CFG     8'h03

// ****************************************
// timing
// ****************************************
`define LSC_CLK_KHZ           125000
`define LSC_SHUNT_BASE_MS     82
`define LSC_QUEUE_MAX         3'h4

`endif

/* File: lsc_pkg.sv */
// types shared by the limit status and sampling configuration block
package lsc_pkg;

  // one channel's comparison results for a finished measurement
  typedef struct packed {
    logic valid;          // one-cycle pulse: a new measurement is done
    logic below_low;      // measurement under its low limit
    logic at_crit;        // measurement at or above its critical limit
    logic below_release;  // measurement under critical limit minus hysteresis
  } lsc_meas_t;

  // configuration fields handed to the measurement engine
  typedef struct packed {
    logic       spike_route_select;
    logic [1:0] supply_averaging;
    logic [1:0] shunt_averaging;
    logic [1:0] shunt_sample_period;
    logic [1:0] shunt_full_scale;
  } lsc_cfg_t;

endpackage

/* File: lsc_top.sv */
// limit status flags, warning and critical pins, sampling configuration
//
// Contract
// - low-limit breach sets channel under flag
// - any under flag sets under summary
// - read clears flags; summary only if clean
// - under flags sticky until read
// - warning pin: flag, queue met, unmasked
// - at or above critical sets severe flag
// - severe summary follows any severe flag
// - reading severe status clears nothing
// - severe flag clears below limit minus hysteresis
// - critical pin on any severe flag
// - route bit picks pin for spikes
// - warning spike needs comparator mode, unmasked
// - critical spike ignores all masks
// - queue codes mean one to four
// - supply averaging field, reset disabled
// - shunt averaging field bits five four
// - shunt sample period 82/82/164/328 ms
// - shunt update every period times averages
// - shunt full scale bits one zero
// - masked channel never drives warning pin
`timescale 1ns/1ps
`include "lsc_regs.svh"

module lsc_top #(
  parameter int unsigned SHUNT_BASE_CYC = `LSC_SHUNT_BASE_MS * `LSC_CLK_KHZ
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  input  wire logic [7:0]            REG_WDATA,
  output logic      [7:0]            REG_RDATA,
  input  wire lsc_pkg::lsc_meas_t [2:0] MEAS,
  input  wire logic [2:0]            CHANNEL_MASK,
  input  wire logic                  PEAK_MASK,
  input  wire logic                  COMPARATOR_MODE,
  input  wire logic [1:0]            TEMP_QUEUE,
  input  wire logic                  SPIKE_DETECT,
  output logic                       MASKABLE_WARNING_PIN_N,
  output logic                       CRITICAL_FAULT_PIN_N,
  output logic                       UNDER_SUMMARY,
  output logic                       CRITICAL_SUMMARY,
  output lsc_pkg::lsc_cfg_t          CFG,
  output logic                       SHUNT_UPDATE
);
  import lsc_pkg::*;

  // ****************************************
  // register access decode
  // ****************************************
  logic [7:0] supply_cfg_r;
  logic [7:0] shunt_cfg_r;
  logic [2:0] under_r;
  logic [2:0] crit_r;
  logic [2:0] crit_nxt;
  logic [2:0] hit;
  logic [2:0] cond_r;
  logic [1:0] queue [3];
  logic       rd_under;
  logic       rd_crit;
  logic       under_sum_r;
  logic       crit_sum_r;
  logic       warn_nxt;

  assign rd_under = REG_RD && (REG_ADDR == `LSC_OFS_UNDER_STATUS);
  assign rd_crit  = REG_RD && (REG_ADDR == `LSC_OFS_CRIT_STATUS);

  // queue depth per channel: 0 temp, 1 supply, 2 shunt
  assign queue[0] = TEMP_QUEUE;
  assign queue[1] = supply_cfg_r[`LSC_POS_SUPPLY_QUEUE +: 2];
  assign queue[2] = shunt_cfg_r[`LSC_POS_SHUNT_QUEUE +: 2];

  // ****************************************
  // configuration registers
  // ****************************************
  // writable bits only; reserved bits 6..4 of the supply register read zero
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      supply_cfg_r <= `LSC_RST_SUPPLY_CFG;
      shunt_cfg_r  <= `LSC_RST_SHUNT_CFG;
    end else if (REG_WR) begin
      if (REG_ADDR == `LSC_OFS_SUPPLY_CFG) begin
        supply_cfg_r <= REG_WDATA & 8'h8f;
      end
      if (REG_ADDR == `LSC_OFS_SHUNT_CFG) begin
        shunt_cfg_r <= REG_WDATA;
      end
    end
  end

  // configuration fields to the measurement engine
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CFG <= '0;
    end else begin
      CFG.spike_route_select  <= supply_cfg_r[`LSC_BIT_SPIKE_ROUTE];
      CFG.supply_averaging    <= supply_cfg_r[`LSC_POS_SUPPLY_AVG +: 2];
      CFG.shunt_averaging     <= shunt_cfg_r[`LSC_POS_SHUNT_AVG +: 2];
      CFG.shunt_sample_period <= shunt_cfg_r[`LSC_POS_SHUNT_PERIOD +: 2];
      CFG.shunt_full_scale    <= shunt_cfg_r[`LSC_POS_SHUNT_RANGE +: 2];
    end
  end

  // ****************************************
  // per-channel limit checking
  // ****************************************
  for (genvar i = 0; i < 3; i++) begin : g_chan
    logic [2:0] run_r;

    // consecutive under-limit counter, saturating at four
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        run_r <= 3'h0;
      end else if (MEAS[i].valid) begin
        if (!MEAS[i].below_low) begin
          run_r <= 3'h0;
        end else if (run_r != `LSC_QUEUE_MAX) begin
          run_r <= run_r + 3'h1;
        end
      end
    end

    // queue code n needs n+1 consecutive breaches
    assign hit[i] = MEAS[i].valid && MEAS[i].below_low
                    && (run_r >= {1'b0, queue[i]});

    // live condition of the latest measurement
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        cond_r[i] <= 1'b0;
      end else if (MEAS[i].valid) begin
        cond_r[i] <= MEAS[i].below_low;
      end
    end

    // severe flag: set at limit, released below limit minus hysteresis
    always_comb begin
      crit_nxt[i] = crit_r[i];
      if (MEAS[i].valid && MEAS[i].below_release) begin
        crit_nxt[i] = 1'b0;
      end
      if (MEAS[i].valid && MEAS[i].at_crit) begin
        crit_nxt[i] = 1'b1;
      end
    end
  end

  // ****************************************
  // under-limit status and summary
  // ****************************************
  // set wins over the clear of a read in the same cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      under_r <= 3'h0;
    end else begin
      under_r <= (under_r & ~{3{rd_under}}) | hit;
    end
  end

  // summary cleared by a read only once no channel is still low
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      under_sum_r <= 1'b0;
    end else if (hit != 3'h0) begin
      under_sum_r <= 1'b1;
    end else if (rd_under && (cond_r == 3'h0)) begin
      under_sum_r <= 1'b0;
    end
  end

  // ****************************************
  // critical status and summary
  // ****************************************
  // a read has no effect here
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      crit_r     <= 3'h0;
      crit_sum_r <= 1'b0;
    end else begin
      crit_r     <= crit_nxt;
      crit_sum_r <= (crit_nxt != 3'h0);
    end
  end

  assign UNDER_SUMMARY    = under_sum_r;
  assign CRITICAL_SUMMARY = crit_sum_r;

  // ****************************************
  // pins, active low
  // ****************************************
  always_comb begin
    warn_nxt = ((under_r & ~CHANNEL_MASK) != 3'h0);
    if (SPIKE_DETECT && !supply_cfg_r[`LSC_BIT_SPIKE_ROUTE]
        && COMPARATOR_MODE && !PEAK_MASK) begin
      warn_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      MASKABLE_WARNING_PIN_N <= 1'b1;
      CRITICAL_FAULT_PIN_N   <= 1'b1;
    end else begin
      MASKABLE_WARNING_PIN_N <= ~warn_nxt;
      CRITICAL_FAULT_PIN_N   <= ~((crit_r != 3'h0)
        || (SPIKE_DETECT && supply_cfg_r[`LSC_BIT_SPIKE_ROUTE]));
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `LSC_OFS_UNDER_STATUS: REG_RDATA <= {under_r[2], under_r[1], 5'h00, under_r[0]};
        `LSC_OFS_CRIT_STATUS:  REG_RDATA <= {crit_r[2], crit_r[1], 5'h00, crit_r[0]};
        `LSC_OFS_SUPPLY_CFG:   REG_RDATA <= supply_cfg_r;
        `LSC_OFS_SHUNT_CFG:    REG_RDATA <= shunt_cfg_r;
        default:               REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // shunt result update timer
  // ****************************************
  logic [23:0] unit_cnt_r;
  logic [5:0]  mult_cnt_r;
  logic [2:0]  t_shift;
  logic [5:0]  mult_total;

  // period codes 00 and 01 are the same base time
  assign t_shift    = shunt_cfg_r[`LSC_POS_SHUNT_PERIOD + 1]
                      ? {1'b0, shunt_cfg_r[`LSC_POS_SHUNT_PERIOD +: 2]} - 3'h1 : 3'h0;
  assign mult_total = 6'h01 << (t_shift + {1'b0, shunt_cfg_r[`LSC_POS_SHUNT_AVG +: 2]});

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      unit_cnt_r   <= 24'h000000;
      mult_cnt_r   <= 6'h00;
      SHUNT_UPDATE <= 1'b0;
    end else begin
      SHUNT_UPDATE <= 1'b0;
      if (unit_cnt_r >= 24'(SHUNT_BASE_CYC - 1)) begin
        unit_cnt_r <= 24'h000000;
        if (mult_cnt_r >= mult_total - 6'h01) begin
          mult_cnt_r   <= 6'h00;
          SHUNT_UPDATE <= 1'b1;
        end else begin
          mult_cnt_r <= mult_cnt_r + 6'h01;
        end
      end else begin
        unit_cnt_r <= unit_cnt_r + 24'h000001;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_clean_read;
    rd_under && (hit == 3'h0) && (cond_r == 3'h0);
  endsequence

  property p_under_set;
    (hit != 3'h0) |=> ((under_r & $past(hit)) == $past(hit));
  endproperty
  a_under_set: assert property (p_under_set) else $error("under flag not set");

  property p_under_sum;
    (under_r != 3'h0) |-> under_sum_r;
  endproperty
  a_under_sum: assert property (p_under_sum) else $error("under summary missing");

  property p_read_clear;
    s_clean_read |=> (under_r == 3'h0) && !under_sum_r;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_sticky;
    !rd_under |=> ((under_r & $past(under_r)) == $past(under_r));
  endproperty
  a_sticky: assert property (p_sticky) else $error("under flag lost");

  property p_crit_sum;
    crit_sum_r == (crit_r != 3'h0);
  endproperty
  a_crit_sum: assert property (p_crit_sum) else $error("critical summary wrong");

  property p_crit_read;
    rd_crit && (MEAS[0].valid | MEAS[1].valid | MEAS[2].valid) == 1'b0
      |=> crit_r == $past(crit_r);
  endproperty
  a_crit_read: assert property (p_crit_read) else $error("critical read side effect");

  property p_crit_pin;
    (crit_r != 3'h0) |=> !CRITICAL_FAULT_PIN_N;
  endproperty
  a_crit_pin: assert property (p_crit_pin) else $error("critical pin idle");

  property p_mask;
    ((under_r & ~CHANNEL_MASK) == 3'h0) && !SPIKE_DETECT |=> MASKABLE_WARNING_PIN_N;
  endproperty
  a_mask: assert property (p_mask) else $error("masked warning asserted");

  property p_spike_crit;
    SPIKE_DETECT && supply_cfg_r[`LSC_BIT_SPIKE_ROUTE] |=> !CRITICAL_FAULT_PIN_N;
  endproperty
  a_spike_crit: assert property (p_spike_crit) else $error("spike not on critical pin");

endmodule

/* File: lsc_host.sv */
// register host model driving the block's strobe bus
`timescale 1ns/1ps

module lsc_host (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ****************************************
  // idle bus
  // ****************************************
  // strobes low from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data no longer shows the value
  endtask

  // one read, data taken a full cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the limit status and sampling configuration block
`timescale 1ns/1ps

module tb;
  import lsc_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         reg_addr;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_wdata;
  logic [7:0]         reg_rdata;
  lsc_meas_t [2:0]    meas;
  logic [2:0]         chan_mask;
  logic               peak_mask;
  logic               comp_mode;
  logic [1:0]         temp_queue;
  logic               spike;
  logic               warn_n;
  logic               crit_n;
  logic               under_sum;
  logic               crit_sum;
  lsc_cfg_t           cfg;
  logic               shunt_upd;
  int                 n_mismatch = 0;
  int                 tests_run = 0;
  logic [7:0]         cfgs [3] = '{8'h03, 8'h18, 8'hfc};
  int                 gaps [3] = '{10, 40, 320};

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  lsc_host lsc_host_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  lsc_top #(.SHUNT_BASE_CYC(10)) lsc_top_i (.CLK_SYS(clk_sys), .RST(rst),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .MEAS(meas), .CHANNEL_MASK(chan_mask), .PEAK_MASK(peak_mask),
    .COMPARATOR_MODE(comp_mode), .TEMP_QUEUE(temp_queue), .SPIKE_DETECT(spike),
    .MASKABLE_WARNING_PIN_N(warn_n), .CRITICAL_FAULT_PIN_N(crit_n),
    .UNDER_SUMMARY(under_sum), .CRITICAL_SUMMARY(crit_sum), .CFG(cfg),
    .SHUNT_UPDATE(shunt_upd));

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    lsc_host_i.rd(a, d);
    chk(d, exp);
  endtask

  // one measurement pulse, then time for flags and pins to settle
  task automatic hit(input int ch, input logic bl, input logic ac, input logic br);
    @(negedge clk_sys);
    meas[ch] = '{1'b1, bl, ac, br};
    @(negedge clk_sys);
    meas[ch] = '0;
    repeat (3) @(negedge clk_sys);
  endtask

  // cycles until the next update pulse, bounded
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 4000) begin
        n_mismatch++;
        $display("Error at %0t: no update pulse", $time);
        summarize();
      end
    end while (shunt_upd !== 1'b1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n;
    meas = '0;
    chan_mask = 3'h0;
    peak_mask = 1'b0;
    comp_mode = 1'b0;
    temp_queue = 2'h0;
    spike = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    // reset values and access kinds
    rchk(8'h36, 8'h00);
    rchk(8'h37, 8'h00);
    rchk(8'h50, 8'h80);
    rchk(8'h51, 8'h03);
    rchk(8'h40, 8'h00);
    chk({7'h0, cfg.spike_route_select}, 8'h01);
    chk({6'h0, cfg.shunt_full_scale}, 8'h03);
    lsc_host_i.wr(8'h50, 8'hff);
    lsc_host_i.wr(8'h36, 8'hff);
    rchk(8'h50, 8'h8f);
    rchk(8'h36, 8'h00);
    chk({6'h0, cfg.supply_averaging}, 8'h03);
    lsc_host_i.wr(8'h50, 8'h80);
    // update interval per period and averaging code
    for (int i = 0; i < 3; i++) begin
      lsc_host_i.wr(8'h51, cfgs[i]);
      repeat (3) wait_upd(n);
      tests_run++;
      if (n != gaps[i]) begin
        n_mismatch++;
        $display("Error at %0t: update gap %0d expected %0d", $time, n, gaps[i]);
      end
    end
    chk({6'h0, cfg.shunt_averaging}, 8'h03);
    chk({6'h0, cfg.shunt_full_scale}, 8'h00);
    chk({6'h0, cfg.shunt_sample_period}, 8'h03);
    // shunt queue of four, broken run restarts
    for (int i = 0; i < 3; i++) hit(2, 1'b1, 1'b0, 1'b0);
    hit(2, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) hit(2, 1'b1, 1'b0, 1'b0);
    rchk(8'h36, 8'h00);
    hit(2, 1'b1, 1'b0, 1'b0);
    chk({7'h0, under_sum}, 8'h01);
    hit(2, 1'b0, 1'b0, 1'b0);
    chk({7'h0, warn_n}, 8'h00);
    rchk(8'h36, 8'h80);
    rchk(8'h36, 8'h00);
    chk({7'h0, under_sum}, 8'h00);
    // masked supply and temp flags, summary held while condition stays
    chan_mask = 3'h3;
    hit(1, 1'b1, 1'b0, 1'b0);
    hit(0, 1'b1, 1'b0, 1'b0);
    chk({7'h0, warn_n}, 8'h01);
    rchk(8'h36, 8'h41);
    chk({7'h0, under_sum}, 8'h01);
    hit(1, 1'b0, 1'b0, 1'b0);
    hit(0, 1'b0, 1'b0, 1'b0);
    rchk(8'h36, 8'h00);
    chk({7'h0, under_sum}, 8'h00);
    // temp queue code 01 needs two breaches, supply queue code 10 needs three
    temp_queue = 2'h1;
    lsc_host_i.wr(8'h50, 8'h88);
    hit(0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 2; i++) hit(1, 1'b1, 1'b0, 1'b0);
    rchk(8'h36, 8'h00);
    hit(0, 1'b1, 1'b0, 1'b0);
    hit(1, 1'b1, 1'b0, 1'b0);
    rchk(8'h36, 8'h41);
    hit(0, 1'b0, 1'b0, 1'b0);
    hit(1, 1'b0, 1'b0, 1'b0);
    rchk(8'h36, 8'h00);
    chk({7'h0, under_sum}, 8'h00);
    lsc_host_i.wr(8'h50, 8'h80);
    // critical flags with hysteresis release
    hit(0, 1'b0, 1'b1, 1'b0);
    chk({7'h0, crit_sum}, 8'h01);
    chk({7'h0, crit_n}, 8'h00);
    hit(2, 1'b0, 1'b1, 1'b0);
    rchk(8'h37, 8'h81);
    rchk(8'h37, 8'h81);
    hit(0, 1'b0, 1'b0, 1'b0);
    hit(0, 1'b0, 1'b0, 1'b1);
    rchk(8'h37, 8'h80);
    chk({7'h0, crit_sum}, 8'h01);
    hit(2, 1'b0, 1'b0, 1'b1);
    rchk(8'h37, 8'h00);
    chk({6'h0, crit_sum, crit_n}, 8'h01);
    // spike routing
    chan_mask = 3'h7;
    peak_mask = 1'b1;
    spike = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({6'h0, crit_n, warn_n}, 8'h01);
    chan_mask = 3'h0;
    peak_mask = 1'b0;
    comp_mode = 1'b1;
    lsc_host_i.wr(8'h50, 8'h00);
    repeat (3) @(negedge clk_sys);
    chk({6'h0, crit_n, warn_n}, 8'h02);
    peak_mask = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({7'h0, warn_n}, 8'h01);
    peak_mask = 1'b0;
    comp_mode = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({7'h0, warn_n}, 8'h01);
    spike = 1'b0;
    summarize();
  end
endmodule
